//--- design/sysctl_pkg.sv
// Shared constants and carriers for the system control coprocessor register map
package sysctl_pkg;

    localparam int LOC_COUNT = 16;
    localparam logic [3:0] LOC_IDENT = 4'h0;
    localparam logic [3:0] LOC_CONTROL = 4'h1;
    localparam logic [3:0] LOC_CACHABLE = 4'h2;
    localparam logic [3:0] LOC_BUFFERABLE = 4'h3;
    localparam logic [3:0] LOC_PERMISSIONS = 4'h5;
    localparam logic [3:0] LOC_BASE_SIZE = 4'h6;
    localparam logic [3:0] LOC_MAINTENANCE = 4'h7;
    localparam logic [3:0] LOC_LOCKDOWN = 4'h9;
    localparam logic [3:0] LOC_TEST = 4'hf;

    localparam logic [2:0] OP2_CACHE_TYPE = 3'h1;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam int VECTOR_HIGH_BIT = 13;

    // Identification word fields
    localparam logic [7:0] IDENT_ARCH = 8'h06; // Arbitrary value
    localparam logic [7:0] IDENT_IMPL_DEFAULT = 8'h5a;
    localparam logic [11:0] IDENT_PART_DEFAULT = 12'h123;
    localparam logic [3:0] IDENT_REV_DEFAULT = 4'h0;

    // Cache geometry fields
    localparam logic [2:0] CTYPE_ZERO = 3'h0;
    localparam logic [3:0] CTYPE_KIND = 4'h7;
    localparam logic CTYPE_SPLIT = 1'b1;
    localparam logic [2:0] GEOM_SIZE_4K = 3'h3;
    localparam logic [2:0] GEOM_WAYS_64 = 3'h6;
    localparam logic GEOM_MULT = 1'b0;
    localparam logic [1:0] GEOM_LEN_4W = 2'h1;

    typedef struct packed {
        logic [2:0] zero;
        logic [2:0] size;
        logic [2:0] ways;
        logic mult;
        logic [1:0] len;
    } geometry_s;

    typedef enum logic [2:0] {
        INSTR_TRANSFER = 3'b001,
        INSTR_DATA_OP = 3'b010,
        INSTR_LOAD_STORE = 3'b100
    } instr_kind_e;

    typedef struct packed {
        logic valid;
        instr_kind_e kind;
        logic read;
        logic [2:0] primary_opcode;
        logic [3:0] target;
        logic [3:0] auxiliary;
        logic [2:0] secondary_opcode;
        logic [31:0] wdata;
    } request_s;

    typedef struct packed {
        logic done;
        logic undefined_trap;
        logic [31:0] rdata;
    } response_s;

endpackage : sysctl_pkg

//--- design/sysctl_decode.sv
// Instruction field decode for the system control coprocessor
`timescale 1ns/10ps
module sysctl_decode
    import sysctl_pkg::*;
(
    input wire request_s req,
    input wire logic privileged,
    output logic accept,
    output logic trap,
    output logic write_en,
    output logic read_en
);

    always_comb
    begin
        accept = 1'b0;
        trap = 1'b0;
        if (req.valid)
        begin
            case (req.kind)
                INSTR_TRANSFER:
                begin
                    accept = privileged;
                    trap = !privileged;
                end
                INSTR_DATA_OP: trap = 1'b1;
                INSTR_LOAD_STORE: trap = 1'b1;
                default: trap = 1'b1;
            endcase
        end
        read_en = accept && req.read;
        write_en = accept && !req.read;
    end

endmodule : sysctl_decode

//--- design/sysctl_bank.sv
// Small register bank for multiplexed coprocessor locations
`timescale 1ns/10ps
module sysctl_bank
    import sysctl_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int WIDTH = 32
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic wr,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Storage cleared at reset so every state bit starts at zero
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_word
            always_ff @(posedge clk_sys or negedge reset_n)
            begin
                if (!reset_n)
                    mem[g] <= WIDTH'(REG_RESET);
                else if (wr && waddr == g)
                    mem[g] <= wdata;
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            rdata <= '0;
        else
            rdata <= mem[raddr];
    end

endmodule : sysctl_bank

//--- design/system_control_register_map.sv
// System control coprocessor register map: decode, storage and read-back
// How it works
// - Sixteen locations; target register field picks the location.
// - Locations 0, 2 hold several registers chosen by secondary opcode; 5, 6 by auxiliary field.
// - Location 0 read with secondary opcode not 1 returns identification word.
// - Location 0 read with secondary opcode 1 returns cache type word.
// - Reset zeroes all state; vector-high bit then loaded from its synchronised init input after release.
// - Register transfers accepted only in privileged mode.
// - Data ops, loads, stores and unprivileged transfers raise undefined trap.
// - Direction bit 1 means read, 0 means write.
// - Auxiliary field bits 2:0 pick sub-register inside locations 5 and 6.
// - Any access leaves no lasting harm; a later write or reset recovers.
// - Identification word: implementer, architecture 23:16, part 15:4, revision 3:0.
// - Cache type: zeros 31:29, kind 0111, split bit, data then instruction geometry.
// - Geometry: three zeros, size, ways, multiplier, line length.
// - Both geometries: size 011, ways 110, multiplier 0, length 01.
// - Size codes 512B doubling up to 64KB.
// - Ways codes direct mapped doubling up to 128-way.
// - Length codes 2 words doubling up to 16 words.
`timescale 1ns/10ps
module system_control_register_map
    import sysctl_pkg::*;
#(
    parameter logic [7:0] IDENT_IMPL = IDENT_IMPL_DEFAULT, // Arbitrary value
    parameter logic [11:0] IDENT_PART = IDENT_PART_DEFAULT, // Arbitrary value
    parameter logic [3:0] IDENT_REV = IDENT_REV_DEFAULT
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic vector_high_init,
    input wire logic privileged,
    input wire request_s req,
    output response_s resp,
    output logic [31:0] control_out,
    output logic [7:0] cachable_data_out,
    output logic [7:0] cachable_instr_out,
    output logic [7:0] bufferable_out,
    output logic maintenance_strobe,
    output logic [31:0] maintenance_data
);

    logic accept;
    logic trap;
    logic write_en;
    logic read_en;
    logic [31:0] global_control;
    logic [31:0] region_cachable [2];
    logic [31:0] region_bufferable;
    logic [31:0] cache_lockdown;
    logic [31:0] test_access;
    logic bank_wr;
    logic [3:0] bank_addr;
    logic [31:0] bank_rdata;
    logic read_pending;
    logic read_from_bank;
    logic [31:0] held_rdata;
    logic vector_init_seen;
    logic [2:0] vinit_sync;
    logic [2:0] settle;
    logic next_ready;
    geometry_s cache_geom;
    logic [31:0] ident_word;
    logic [31:0] cache_type_word;

    sysctl_decode u_decode
    (
        .req(req),
        .privileged(privileged),
        .accept(accept),
        .trap(trap),
        .write_en(write_en),
        .read_en(read_en)
    );

    // Fixed words
    assign cache_geom = '{zero: 3'h0, size: GEOM_SIZE_4K, ways: GEOM_WAYS_64,
        mult: GEOM_MULT, len: GEOM_LEN_4W};
    assign ident_word = {IDENT_IMPL, IDENT_ARCH, IDENT_PART, IDENT_REV};
    assign cache_type_word = {CTYPE_ZERO, CTYPE_KIND, CTYPE_SPLIT, cache_geom, cache_geom};

    // Locations 5 and 6 each carry eight registers selected by auxiliary field bits 2:0
    // alone; the bank keeps that storage out of the flop pile
    function automatic logic is_banked(input logic [3:0] loc);
        is_banked = (loc == LOC_PERMISSIONS) || (loc == LOC_BASE_SIZE);
    endfunction : is_banked

    assign bank_wr = write_en && is_banked(req.target);
    assign bank_addr = {req.target == LOC_BASE_SIZE, req.auxiliary[2:0]} ^ 4'h0;

    sysctl_bank #(.DEPTH(16), .WIDTH(32)) u_bank
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .wr(bank_wr),
        .waddr(bank_addr),
        .wdata(req.wdata),
        .raddr(bank_addr),
        .rdata(bank_rdata)
    );

    // Vector-high init passes a three-stage synchroniser; settle fills with ones after
    // release so the strap is never judged on the cleared stages
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vinit_sync <= 3'h0;
            settle <= 3'h0;
        end
        else
        begin
            vinit_sync <= {vinit_sync[1:0], vector_high_init};
            settle <= {settle[1:0], 1'b1};
        end
    end

    // Register writes; location 0 ignores writes
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            global_control <= REG_RESET;
            region_cachable[0] <= REG_RESET;
            region_cachable[1] <= REG_RESET;
            region_bufferable <= REG_RESET;
            cache_lockdown <= REG_RESET;
            test_access <= REG_RESET;
            vector_init_seen <= 1'b0;
        end
        else
        begin
            // Strap caught once the synchroniser has settled after release
            if (!vector_init_seen && settle[2] && vinit_sync[2] == vinit_sync[1])
            begin
                vector_init_seen <= 1'b1;
                global_control[VECTOR_HIGH_BIT] <= vinit_sync[2];
            end
            if (write_en)
            begin
                case (req.target)
                    LOC_CONTROL: global_control <= req.wdata;
                    LOC_CACHABLE: region_cachable[req.secondary_opcode[0]] <= req.wdata;
                    LOC_BUFFERABLE: region_bufferable <= req.wdata;
                    LOC_LOCKDOWN: cache_lockdown <= req.wdata;
                    LOC_TEST: test_access <= req.wdata;
                    default: ;
                endcase
            end
        end
    end

    // Read data capture
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            held_rdata <= 32'h0;
            read_from_bank <= 1'b0;
        end
        else if (read_en)
        begin
            read_from_bank <= is_banked(req.target);
            case (req.target)
                LOC_IDENT:
                    held_rdata <= (req.secondary_opcode == OP2_CACHE_TYPE) ?
                        cache_type_word : ident_word;
                LOC_CONTROL: held_rdata <= global_control;
                LOC_CACHABLE: held_rdata <= region_cachable[req.secondary_opcode[0]];
                LOC_BUFFERABLE: held_rdata <= region_bufferable;
                LOC_LOCKDOWN: held_rdata <= cache_lockdown;
                LOC_TEST: held_rdata <= test_access;
                default: held_rdata <= 32'h0;
            endcase
        end
    end

    // Response pulses one cycle after the request
    assign next_ready = read_en || write_en || trap;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            read_pending <= 1'b0;
            resp <= '0;
        end
        else
        begin
            read_pending <= read_en;
            resp.done <= next_ready;
            resp.undefined_trap <= trap;
            if (read_pending)
                resp.rdata <= read_from_bank ? bank_rdata : held_rdata;
        end
    end

    // Maintenance location is write-only and only pulses a command out
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            maintenance_strobe <= 1'b0;
            maintenance_data <= 32'h0;
        end
        else
        begin
            maintenance_strobe <= write_en && req.target == LOC_MAINTENANCE;
            if (write_en && req.target == LOC_MAINTENANCE)
                maintenance_data <= req.wdata;
        end
    end

    // Configuration views, registered
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            control_out <= 32'h0;
            cachable_data_out <= 8'h0;
            cachable_instr_out <= 8'h0;
            bufferable_out <= 8'h0;
        end
        else
        begin
            control_out <= global_control;
            cachable_data_out <= region_cachable[0][7:0];
            cachable_instr_out <= region_cachable[1][7:0];
            bufferable_out <= region_bufferable[7:0];
        end
    end

endmodule : system_control_register_map

//--- verif/sysctl_asserts.sv
// Port checks for the system control register map
`timescale 1ns/10ps
module sysctl_asserts
    import sysctl_pkg::*;
#(
    parameter logic [7:0] IDENT_IMPL = IDENT_IMPL_DEFAULT,
    parameter logic [11:0] IDENT_PART = IDENT_PART_DEFAULT,
    parameter logic [3:0] IDENT_REV = IDENT_REV_DEFAULT
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic privileged,
    input wire request_s req,
    input wire response_s resp,
    input wire logic [31:0] control_out,
    input wire logic maintenance_strobe,
    input wire logic [31:0] maintenance_data
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire logic xfer = req.valid && req.kind == INSTR_TRANSFER && privileged;
    wire logic wr = xfer && !req.read;
    wire logic rd0 = xfer && req.read && req.target == LOC_IDENT;
    property p_done; req.valid |=> resp.done; endproperty
    a_done: assert property (p_done) else $error("no done after request");
    property p_idle; !req.valid |=> !resp.done && !resp.undefined_trap; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_unpriv; req.valid && !privileged |=> resp.undefined_trap; endproperty
    a_unpriv: assert property (p_unpriv) else $error("unprivileged access not trapped");
    property p_kind; req.valid && req.kind != INSTR_TRANSFER |=> resp.undefined_trap; endproperty
    a_kind: assert property (p_kind) else $error("data op or load store not trapped");
    property p_accept; xfer |=> !resp.undefined_trap; endproperty
    a_accept: assert property (p_accept) else $error("privileged transfer trapped");
    property p_ident;
        rd0 && req.secondary_opcode != OP2_CACHE_TYPE |->
            ##2 resp.rdata == {IDENT_IMPL, IDENT_ARCH, IDENT_PART, IDENT_REV};
    endproperty
    a_ident: assert property (p_ident) else $error("bad identification word");
    property p_ctype; rd0 && req.secondary_opcode == OP2_CACHE_TYPE |-> ##2 resp.rdata == 32'h0f0f10f1;
    endproperty
    a_ctype: assert property (p_ctype) else $error("bad cache type word");
    property p_ctrl; wr && req.target == LOC_CONTROL |-> ##2 control_out == $past(req.wdata, 2);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control write lost");
    property p_maint;
        wr && req.target == LOC_MAINTENANCE |=> maintenance_strobe && maintenance_data == $past(req.wdata);
    endproperty
    a_maint: assert property (p_maint) else $error("no maintenance strobe");
    property p_strobe; maintenance_strobe |-> $past(wr && req.target == LOC_MAINTENANCE); endproperty
    a_strobe: assert property (p_strobe) else $error("stray maintenance strobe");
    c_ctype: cover property (rd0 && req.secondary_opcode == OP2_CACHE_TYPE);
    c_unpriv: cover property (req.valid && !privileged);
    c_maint: cover property (wr && req.target == LOC_MAINTENANCE);
endmodule : sysctl_asserts

bind system_control_register_map sysctl_asserts #(.IDENT_IMPL(IDENT_IMPL),
    .IDENT_PART(IDENT_PART), .IDENT_REV(IDENT_REV)) i_sysctl_asserts (.clk_sys(clk_sys),
    .reset_n(reset_n), .privileged(privileged), .req(req), .resp(resp),
    .control_out(control_out), .maintenance_strobe(maintenance_strobe),
    .maintenance_data(maintenance_data));

//--- verif/sysctl_core_model.sv
// Core model issuing coprocessor register transfers
`timescale 1ns/10ps
module sysctl_core_model
    import sysctl_pkg::*;
(
    input wire logic clk_sys,
    input wire response_s resp,
    output request_s req,
    output logic privileged
);
    logic got_done;
    logic got_trap;
    logic [31:0] got_rdata;
    initial req = '0;
    initial privileged = 1'b0;
    task automatic issue(input instr_kind_e k, input logic rd, input logic [3:0] t,
        input logic [3:0] a, input logic [2:0] o, input logic [31:0] w, input logic p);
        @(posedge clk_sys);
        privileged <= p;
        req <= '{1'b1, k, rd, 3'h0, t, a, o, w};
        @(posedge clk_sys);
        req.valid <= 1'b0;
        // Released data never repeats the last word
        req.wdata <= ~w;
        // Done and trap stand only for the cycle after the taking edge
        #1;
        got_done = resp.done;
        got_trap = resp.undefined_trap;
        @(posedge clk_sys);
        #1;
        got_rdata = resp.rdata;
    endtask : issue
endmodule : sysctl_core_model

//--- verif/tb_system_control_register_map.sv
// Testbench for the system control register map
`timescale 1ns/10ps
module tb_system_control_register_map
    import sysctl_pkg::*;
;
    // Identity values are arbitrary
    localparam logic [31:0] IDENT = {8'h3c, IDENT_ARCH, 12'h5a7, 4'h2};
    typedef struct packed {logic wr; logic [3:0] t; logic [3:0] a; logic [2:0] o;
        logic [31:0] w; logic [31:0] e;} row_s;
    localparam row_s ROWS [14] = '{'{1, 1, 0, 0, 32'h000010fd, 32'h000010fd},
        '{1, 2, 0, 0, 32'ha5, 32'ha5}, '{1, 2, 0, 1, 32'h5a, 32'h5a}, '{0, 2, 0, 0, 0, 32'ha5},
        '{1, 3, 0, 0, 32'hc3, 32'hc3}, '{1, 5, 3, 0, 32'h13572468, 32'h13572468},
        '{1, 5, 4, 0, 32'h0badf00d, 32'h0badf00d}, '{0, 5, 3, 0, 0, 32'h13572468},
        '{1, 6, 5, 0, 32'h0000ff3f, 32'h0000ff3f}, '{1, 9, 0, 0, 32'h3f, 32'h3f},
        '{1, 15, 0, 0, 32'h89abcdef, 32'h89abcdef}, '{1, 0, 0, 0, 32'hffffffff, IDENT},
        '{1, 7, 0, 0, 32'h11, 0}, '{1, 4, 0, 0, 32'h11111111, 0}};
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic vector_high_init = 1'b1;
    request_s req;
    logic privileged;
    response_s resp;
    logic [31:0] control_out;
    logic [7:0] cd_out;
    logic [7:0] ci_out;
    logic [7:0] bf_out;
    logic [31:0] maint_data;
    int n_mismatch = 0;
    int checked = 0;
    always #5 clk_sys = ~clk_sys;
    system_control_register_map #(.IDENT_IMPL(8'h3c), .IDENT_PART(12'h5a7), .IDENT_REV(4'h2))
        i_system_control_register_map (.clk_sys(clk_sys), .reset_n(reset_n),
        .vector_high_init(vector_high_init), .privileged(privileged), .req(req), .resp(resp),
        .control_out(control_out), .cachable_data_out(cd_out), .cachable_instr_out(ci_out),
        .bufferable_out(bf_out), .maintenance_strobe(), .maintenance_data(maint_data));
    sysctl_core_model i_sysctl_core_model (.clk_sys(clk_sys), .resp(resp), .req(req),
        .privileged(privileged));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic rd_chk(input logic [3:0] t, input logic [3:0] a, input logic [2:0] o,
        input logic [31:0] e);
        i_sysctl_core_model.issue(INSTR_TRANSFER, 1, t, a, o, 32'h0, 1);
        chk({30'h0, i_sysctl_core_model.got_done, i_sysctl_core_model.got_trap}, 32'h2);
        chk(i_sysctl_core_model.got_rdata, e);
    endtask : rd_chk
    task automatic trap_chk(input instr_kind_e k, input logic rd, input logic p);
        i_sysctl_core_model.issue(k, rd, 4'h3, 4'h0, 3'h0, 32'hff, p);
        chk({30'h0, i_sysctl_core_model.got_done, i_sysctl_core_model.got_trap}, 32'h3);
    endtask : trap_chk
    task automatic end_of_test;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rd_chk(1, 0, 0, 32'h00002000);
        for (int i = 0; i < 14; i++)
        begin
            if (ROWS[i].wr)
            begin
                i_sysctl_core_model.issue(INSTR_TRANSFER, 0, ROWS[i].t, ROWS[i].a, ROWS[i].o,
                    ROWS[i].w, 1);
                chk({30'h0, i_sysctl_core_model.got_done, i_sysctl_core_model.got_trap},
                    32'h2);
            end
            // Write-only location is never read back; its command output is compared instead
            if (ROWS[i].t == LOC_MAINTENANCE)
                chk(maint_data, ROWS[i].w);
            else
                rd_chk(ROWS[i].t, ROWS[i].a, ROWS[i].o, ROWS[i].e);
        end
        chk({8'h0, cd_out, ci_out, bf_out}, 32'ha55ac3);
        $display("TEST rows done");
        for (int o = 0; o < 8; o++)
            rd_chk(0, 0, o, (o == 1) ? 32'h0f0f10f1 : IDENT);
        $display("TEST location 0 done");
        trap_chk(INSTR_TRANSFER, 0, 0);
        trap_chk(INSTR_TRANSFER, 1, 0);
        trap_chk(INSTR_DATA_OP, 0, 1);
        trap_chk(INSTR_LOAD_STORE, 1, 1);
        rd_chk(3, 0, 0, 32'hc3);
        $display("TEST refusals done");
        // Second reset with the strap low must clear locations 1, 2 and 5
        @(posedge clk_sys);
        reset_n <= 1'b0;
        vector_high_init <= 1'b0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rd_chk(1, 0, 0, 32'h0);
        rd_chk(2, 0, 0, 32'h0);
        rd_chk(5, 3, 0, 32'h0);
        $display("TEST second reset done");
        end_of_test();
    end
    initial
    begin
        #20000;
        n_mismatch++;
        end_of_test();
    end
endmodule : tb_system_control_register_map
